//--- design/fesq_sequencer.sv
// command sequencer: whole-array erase, pause/resume, security register erase
//
// What this block does
// - whole-array erase on either opcode, only with write latch set
// - whole-array erase runs only if chip select rises right after bit eight
// - busy flag high during whole-array erase; at end busy and latch clear
// - whole-array erase refused if any protect region bit is set
// - pause opcode interrupts page program or page/block erase in progress
// - while paused, reads outside and erase-pause programs are passed on
// - status write and security register erase/program are not pausable
// - after pause latency, write latch clears and paused flag sets
// - paused flag reported at status bit 15, cleared on resume
// - after latency only the paused and anytime acceptance lists are passed on
// - status reads, status interrupt and reset pair accepted during latency
// - resume acts only when paused flag is 1 and busy flag is 0
// - accepted resume clears paused and raises busy within 200 ns
// - resume ignored after power loss ended the paused state
// - security register erase: opcode, 24-bit address, latch set beforehand
// - address top byte zero, bits 15:12 select 1..3, bits 11:9 zero
// - runs only if chip select rises after last address bit; small-block time
// - busy during security erase; at end busy and latch clear
// - security erase ignored for a register whose lock bit is set
`timescale 1ns/1ps
module fesq_sequencer #(
    parameter int CHIP_CLEAR_CYC = fesq_pkg::WHOLE_ARRAY_CLEAR_US * 1000 / fesq_pkg::CLK_PERIOD_NS,
    parameter int SMALL_CLEAR_CYC = fesq_pkg::SMALL_BLOCK_CLEAR_US * 1000 / fesq_pkg::CLK_PERIOD_NS,
    parameter int PROG_PAUSE_CYC = fesq_pkg::PROGRAM_PAUSE_LATENCY_US * 1000 / fesq_pkg::CLK_PERIOD_NS,
    parameter int ERASE_PAUSE_CYC = fesq_pkg::ERASE_PAUSE_LATENCY_US * 1000 / fesq_pkg::CLK_PERIOD_NS
) (
    // system
    input wire logic ref_clk,
    input wire logic reset,
    // serial link
    input wire logic sclk,
    input wire logic csN,
    input wire logic si,
    // configuration and core status
    input wire logic [4:0] protectRegion,
    input wire logic [2:0] otpLockBits,
    input wire logic extBusy,
    input wire logic extPausable,
    input wire logic extIsErase,
    input wire logic powerLoss,
    // flags
    output logic writeLatchFlag,
    output logic opInProgressFlag,
    output logic pausedFlag,
    output logic [15:0] statusWord,
    // commands handed on
    output logic cmdValid,
    output logic [7:0] cmdOp,
    output logic [23:0] cmdAddr,
    output logic pauseReq,
    output logic resumeReq,
    output logic chipEraseGo,
    output logic secEraseGo,
    output logic [1:0] secEraseSel,
    output logic softReset
);
    localparam int RESUME_BOUND = fesq_pkg::RESUME_MAX_CYC;

    typedef struct packed {
        fesq_pkg::fesq_state_t st;
        logic [31:0] cnt;
        logic write_latch_flag;
        logic busy;
        logic paused;
        logic resumeHold;
        logic stale;
        logic eraseType;
        logic rstArm;
        logic [2:0] csSync;
        logic [1:0] pwrSync;
        logic cmdValid;
        logic [7:0] cmdOp;
        logic [23:0] cmdAddr;
        logic pauseReq;
        logic resumeReq;
        logic chipGo;
        logic secGo;
        logic [1:0] secSel;
        logic softRst;
        logic [15:0] status;
    } fesq_seq_t;

    localparam fesq_seq_t SEQ_RESET = '{
        st: fesq_pkg::ST_IDLE,
        cnt: 32'h0,
        write_latch_flag: 1'b0,
        busy: 1'b0,
        paused: 1'b0,
        resumeHold: 1'b0,
        stale: 1'b0,
        eraseType: 1'b0,
        rstArm: 1'b0,
        csSync: 3'h7,
        pwrSync: 2'h0,
        cmdValid: 1'b0,
        cmdOp: 8'h00,
        cmdAddr: 24'h0,
        pauseReq: 1'b0,
        resumeReq: 1'b0,
        chipGo: 1'b0,
        secGo: 1'b0,
        secSel: 2'h0,
        softRst: 1'b0,
        status: fesq_pkg::STATUS_RESET
    };

    fesq_seq_t s_ff;
    fesq_seq_t nxt_s;

    logic [7:0] frameOp;
    logic [23:0] frameAddr;
    logic [5:0] frameBits;
    logic frameEmpty;

    fesq_link_capture u_capture (
        .sclk(sclk),
        .csN(csN),
        .si(si),
        .frameOp(frameOp),
        .frameAddr(frameAddr),
        .frameBits(frameBits),
        .frameEmpty(frameEmpty)
    );

    // ==========================================================
    // acceptance lists
    function automatic logic anytimeCmd(input logic [7:0] op);
        anytimeCmd = (op == fesq_pkg::OP_STATUS1_READ) || (op == fesq_pkg::OP_STATUS2_READ) ||
                     (op == fesq_pkg::OP_STATUS_INT) || (op == fesq_pkg::OP_RESET_ENABLE) ||
                     (op == fesq_pkg::OP_RESET_DEVICE);
    endfunction

    function automatic logic pausedCmd(input logic [7:0] op, input logic isErase);
        logic common;
        logic eraseOnly;
        common = (op == fesq_pkg::OP_READ_DATA) || (op == fesq_pkg::OP_FAST_READ) ||
                 (op == fesq_pkg::OP_DUAL_OUT_READ) || (op == fesq_pkg::OP_DUAL_IO_READ) ||
                 (op == fesq_pkg::OP_PARAM_READ) || (op == fesq_pkg::OP_ID_READ) ||
                 (op == fesq_pkg::OP_MFR_ID_READ) || (op == fesq_pkg::OP_SEC_READ) ||
                 (op == fesq_pkg::OP_WRAP_SETUP) || (op == fesq_pkg::OP_WRITE_DISABLE) ||
                 (op == fesq_pkg::OP_RESUME) || (op == fesq_pkg::OP_POWER_UP);
        eraseOnly = (op == fesq_pkg::OP_WRITE_ENABLE) || (op == fesq_pkg::OP_PAGE_PROG) ||
                    (op == fesq_pkg::OP_DUAL_PAGE_PROG) || (op == fesq_pkg::OP_QUAD_PAGE_PROG);
        pausedCmd = common || (isErase && eraseOnly);
    endfunction

    function automatic logic lockHit(input logic [2:0] locks, input logic [1:0] sel);
        lockHit = (sel == 2'h1 && locks[0]) || (sel == 2'h2 && locks[1]) || (sel == 2'h3 && locks[2]);
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic frameEnd;
        logic exact8;
        logic exact32;
        logic ok;
        logic ownRun;
        logic [1:0] sel;
        logic addrOk;
        frameEnd = 1'b0;
        exact8 = 1'b0;
        exact32 = 1'b0;
        ok = 1'b0;
        ownRun = 1'b0;
        sel = 2'h0;
        addrOk = 1'b0;
        nxt_s = s_ff;
        nxt_s.csSync = {s_ff.csSync[1:0], frameEmpty};
        nxt_s.pwrSync = {s_ff.pwrSync[0], powerLoss};
        nxt_s.cmdValid = 1'b0;
        nxt_s.pauseReq = 1'b0;
        nxt_s.resumeReq = 1'b0;
        nxt_s.chipGo = 1'b0;
        nxt_s.secGo = 1'b0;
        nxt_s.softRst = 1'b0;

        // self-timed operations
        case (s_ff.st)
            fesq_pkg::ST_CHIP, fesq_pkg::ST_SEC: begin
                if (s_ff.cnt == 32'h0) begin
                    nxt_s.st = fesq_pkg::ST_IDLE;
                    nxt_s.write_latch_flag = 1'b0;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 32'h1;
                end
            end
            fesq_pkg::ST_PAUSING: begin
                if (s_ff.cnt == 32'h0) begin
                    nxt_s.st = fesq_pkg::ST_PAUSED;
                    nxt_s.write_latch_flag = 1'b0;
                    nxt_s.paused = 1'b1;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 32'h1;
                end
            end
            fesq_pkg::ST_PAUSED: begin
            end
            default: begin
            end
        endcase

        // loss of power drops the pause for good
        if (s_ff.pwrSync[1] && (s_ff.st == fesq_pkg::ST_PAUSED || s_ff.st == fesq_pkg::ST_PAUSING)) begin
            nxt_s.st = fesq_pkg::ST_IDLE;
            nxt_s.paused = 1'b0;
            nxt_s.stale = 1'b1;
        end

        // judged when chip select rises after at least one link edge; an empty frame never ends one
        frameEnd = s_ff.csSync[1] && !s_ff.csSync[2];
        exact8 = frameBits == fesq_pkg::BITS_OPCODE;
        exact32 = frameBits == fesq_pkg::BITS_WITH_ADDR;
        if (frameEnd && frameBits >= fesq_pkg::BITS_OPCODE) begin
            case (s_ff.st)
                fesq_pkg::ST_PAUSING: ok = anytimeCmd(frameOp);
                fesq_pkg::ST_PAUSED: ok = anytimeCmd(frameOp) || pausedCmd(frameOp, s_ff.eraseType);
                default: ok = 1'b1;
            endcase
        end
        if (ok) begin
            nxt_s.cmdValid = 1'b1;
            nxt_s.cmdOp = frameOp;
            nxt_s.cmdAddr = frameAddr;
            nxt_s.rstArm = frameOp == fesq_pkg::OP_RESET_ENABLE;
            sel = frameAddr[fesq_pkg::SEC_SEL_LSB+3:fesq_pkg::SEC_SEL_LSB+2] == 2'h0
                  ? frameAddr[fesq_pkg::SEC_SEL_LSB+1:fesq_pkg::SEC_SEL_LSB] : 2'h0;
            addrOk = frameAddr[23:fesq_pkg::SEC_TOP_LSB] == fesq_pkg::SEC_ADDR_TOP &&
                     frameAddr[fesq_pkg::SEC_GAP_LSB+2:fesq_pkg::SEC_GAP_LSB] == fesq_pkg::SEC_ADDR_GAP &&
                     sel != 2'h0;
            case (frameOp)
                fesq_pkg::OP_WRITE_ENABLE: begin
                    nxt_s.write_latch_flag = !((s_ff.st == fesq_pkg::ST_CHIP || s_ff.st == fesq_pkg::ST_SEC) && s_ff.cnt == 32'h0);
                end
                fesq_pkg::OP_WRITE_DISABLE: begin
                    nxt_s.write_latch_flag = 1'b0;
                end
                fesq_pkg::OP_CHIP_ERASE_A, fesq_pkg::OP_CHIP_ERASE_B: begin
                    if (exact8 && s_ff.write_latch_flag && protectRegion == 5'h00 && !s_ff.busy &&
                        s_ff.st == fesq_pkg::ST_IDLE) begin
                        nxt_s.st = fesq_pkg::ST_CHIP;
                        nxt_s.cnt = 32'(CHIP_CLEAR_CYC - 1);
                        nxt_s.chipGo = 1'b1;
                    end
                end
                fesq_pkg::OP_SEC_ERASE: begin
                    if (exact32 && s_ff.write_latch_flag && addrOk && !lockHit(otpLockBits, sel) && !s_ff.busy &&
                        s_ff.st == fesq_pkg::ST_IDLE) begin
                        nxt_s.st = fesq_pkg::ST_SEC;
                        nxt_s.cnt = 32'(SMALL_CLEAR_CYC - 1);
                        nxt_s.secGo = 1'b1;
                        nxt_s.secSel = sel;
                    end
                end
                fesq_pkg::OP_PAUSE: begin
                    // own erases never qualify: only a pausable core operation
                    if (exact8 && s_ff.st == fesq_pkg::ST_IDLE && extBusy && extPausable) begin
                        nxt_s.st = fesq_pkg::ST_PAUSING;
                        nxt_s.eraseType = extIsErase;
                        nxt_s.cnt = extIsErase ? 32'(ERASE_PAUSE_CYC - 1) : 32'(PROG_PAUSE_CYC - 1);
                        nxt_s.pauseReq = 1'b1;
                        nxt_s.stale = 1'b0;
                    end
                end
                fesq_pkg::OP_RESUME: begin
                    if (exact8 && s_ff.paused && !s_ff.busy && !s_ff.stale &&
                        s_ff.st == fesq_pkg::ST_PAUSED) begin
                        nxt_s.st = fesq_pkg::ST_IDLE;
                        nxt_s.paused = 1'b0;
                        nxt_s.resumeHold = 1'b1;
                        nxt_s.resumeReq = 1'b1;
                    end
                end
                fesq_pkg::OP_RESET_DEVICE: begin
                    if (s_ff.rstArm) begin
                        nxt_s.st = fesq_pkg::ST_IDLE;
                        nxt_s.write_latch_flag = 1'b0;
                        nxt_s.paused = 1'b0;
                        nxt_s.resumeHold = 1'b0;
                        nxt_s.stale = 1'b0;
                        nxt_s.softRst = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // busy holds from resume until the core shows it running again
        if (extBusy) begin
            nxt_s.resumeHold = 1'b0;
        end
        ownRun = nxt_s.st == fesq_pkg::ST_CHIP || nxt_s.st == fesq_pkg::ST_SEC;
        nxt_s.busy = ownRun || extBusy || nxt_s.resumeHold;
        nxt_s.status = 16'h0000;
        nxt_s.status[fesq_pkg::ST_BUSY_BIT] = nxt_s.busy;
        nxt_s.status[fesq_pkg::ST_LATCH_BIT] = nxt_s.write_latch_flag;
        nxt_s.status[fesq_pkg::ST_LOCK_LSB+2:fesq_pkg::ST_LOCK_LSB] = otpLockBits;
        nxt_s.status[fesq_pkg::ST_PAUSED_BIT] = nxt_s.paused;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_ff <= SEQ_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign writeLatchFlag = s_ff.write_latch_flag;
    assign opInProgressFlag = s_ff.busy;
    assign pausedFlag = s_ff.paused;
    assign statusWord = s_ff.status;
    assign cmdValid = s_ff.cmdValid;
    assign cmdOp = s_ff.cmdOp;
    assign cmdAddr = s_ff.cmdAddr;
    assign pauseReq = s_ff.pauseReq;
    assign resumeReq = s_ff.resumeReq;
    assign chipEraseGo = s_ff.chipGo;
    assign secEraseGo = s_ff.secGo;
    assign secEraseSel = s_ff.secSel;
    assign softReset = s_ff.softRst;

    // ==========================================================
    // checks
    a_chip_needs_latch: assert property (@(posedge ref_clk) disable iff (reset)
        chipEraseGo |-> $past(writeLatchFlag) && $past(protectRegion) == 5'h00 && opInProgressFlag)
        else $error("whole-array erase started without latch or with protection");

    a_chip_busy_run: assert property (@(posedge ref_clk) disable iff (reset)
        chipEraseGo |-> opInProgressFlag [*8])
        else $error("busy flag dropped early in whole-array erase");

    a_erase_end_latch: assert property (@(posedge ref_clk) disable iff (reset)
        (s_ff.st != fesq_pkg::ST_IDLE && s_ff.st != fesq_pkg::ST_PAUSED && s_ff.st != fesq_pkg::ST_PAUSING &&
         s_ff.cnt == 32'h0 && !s_ff.pwrSync[1]) |=> !writeLatchFlag)
        else $error("write latch not cleared at end of erase");

    a_pause_result: assert property (@(posedge ref_clk) disable iff (reset)
        (s_ff.st == fesq_pkg::ST_PAUSING && s_ff.cnt == 32'h0 && !s_ff.pwrSync[1])
        |=> pausedFlag && !writeLatchFlag && statusWord[15])
        else $error("pause latency end did not set paused and clear latch");

    a_pause_source: assert property (@(posedge ref_clk) disable iff (reset)
        pauseReq |-> $past(extPausable) && $past(extBusy) && !pausedFlag)
        else $error("pause taken for an operation that cannot pause");

    a_resume_gate: assert property (@(posedge ref_clk) disable iff (reset)
        resumeReq |-> $past(pausedFlag) && !$past(opInProgressFlag))
        else $error("resume accepted while not paused or busy");

    a_resume_busy: assert property (@(posedge ref_clk) disable iff (reset)
        resumeReq |-> !pausedFlag ##0 (##[0:RESUME_BOUND] opInProgressFlag))
        else $error("resume did not raise busy in time");

    a_sec_lock_addr: assert property (@(posedge ref_clk) disable iff (reset)
        secEraseGo |-> !lockHit($past(otpLockBits), secEraseSel) && secEraseSel != 2'h0)
        else $error("security erase started on locked or bad register");

    a_paused_filter: assert property (@(posedge ref_clk) disable iff (reset)
        (cmdValid && $past(s_ff.st) == fesq_pkg::ST_PAUSED)
        |-> anytimeCmd(cmdOp) || pausedCmd(cmdOp, s_ff.eraseType))
        else $error("command passed on while paused that is not allowed");
endmodule

//--- design/fesq_pkg.sv
// constants shared by the erase/pause sequencer files
package fesq_pkg;

    // ==========================================================
    // command opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_PAUSE = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_READ_DATA = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
    localparam logic [7:0] OP_PARAM_READ = 8'h5a;
    localparam logic [7:0] OP_ID_READ = 8'h9f;
    localparam logic [7:0] OP_MFR_ID_READ = 8'h90;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_WRAP_SETUP = 8'h77;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_DUAL_PAGE_PROG = 8'ha2;
    localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;
    localparam logic [7:0] OP_POWER_UP = 8'hab;
    localparam logic [7:0] OP_STATUS1_READ = 8'h05;
    localparam logic [7:0] OP_STATUS2_READ = 8'h35;
    localparam logic [7:0] OP_STATUS_INT = 8'h25;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET_DEVICE = 8'h99;

    // ==========================================================
    // frame lengths and security register address fields
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_WITH_ADDR = 6'h20;
    localparam logic [7:0] SEC_ADDR_TOP = 8'h00;
    localparam logic [2:0] SEC_ADDR_GAP = 3'h0;
    localparam int SEC_SEL_LSB = 12;
    localparam int SEC_GAP_LSB = 9;
    localparam int SEC_TOP_LSB = 16;

    // ==========================================================
    // status word layout
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_LOCK_LSB = 11;
    localparam int ST_PAUSED_BIT = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESUME_MAX_NS = 200;
    localparam int RESUME_MAX_CYC = RESUME_MAX_NS / CLK_PERIOD_NS;
    localparam int WHOLE_ARRAY_CLEAR_US = 1000;
    localparam int SMALL_BLOCK_CLEAR_US = 100;
    localparam int PROGRAM_PAUSE_LATENCY_US = 20;
    localparam int ERASE_PAUSE_LATENCY_US = 20;
    // host-side spacing between resume and next pause
    localparam int ERASE_RESUME_GAP_MS = 12;
    localparam int PROGRAM_RESUME_GAP_MS = 3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CHIP = 5'h02,
        ST_SEC = 5'h04,
        ST_PAUSING = 5'h08,
        ST_PAUSED = 5'h10
    } fesq_state_t;

endpackage

//--- design/fesq_link_capture.sv
// serial-clock side: shifts in the opcode and address of each frame
`timescale 1ns/1ps
module fesq_link_capture (
    // link
    input wire logic sclk,
    input wire logic csN,
    input wire logic si,
    // frame contents, stable while chip select is high
    output logic [7:0] frameOp,
    output logic [23:0] frameAddr,
    output logic [5:0] frameBits,
    output logic frameEmpty
);
    typedef struct packed {
        logic [5:0] bits;
        logic [31:0] shift;
        logic [7:0] op;
    } fesq_cap_t;

    fesq_cap_t c_ff;
    fesq_cap_t nxt_c;
    logic fresh_ff;

    // ==========================================================
    // set by chip select itself: the link clock stops between frames
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            fresh_ff <= 1'b1;
        end else begin
            fresh_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_c = c_ff;
        if (fresh_ff) begin
            nxt_c.bits = 6'h01;
            nxt_c.shift = {31'h0, si};
        end else begin
            if (c_ff.bits != 6'h3f) begin
                nxt_c.bits = c_ff.bits + 6'h01;
            end
            nxt_c.shift = {c_ff.shift[30:0], si};
            if (c_ff.bits == fesq_pkg::BITS_OPCODE - 6'h01) begin
                nxt_c.op = {c_ff.shift[6:0], si};
            end
        end
    end

    always_ff @(posedge sclk) begin
        c_ff <= nxt_c;
    end

    assign frameOp = c_ff.op;
    assign frameAddr = c_ff.shift[23:0];
    assign frameBits = c_ff.bits;
    assign frameEmpty = fresh_ff;
endmodule

//--- testbench/fesq_spi_host.sv
// serial host model that shifts command frames onto the link
`timescale 1ns/1ps
module fesq_spi_host (
    // link
    output logic sclk,
    output logic csN,
    output logic si
);
    // ==========================================================
    // frame driver
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end

    // clock stands still between frames; data idles at the inverse of its last bit
    task automatic send(input logic [31:0] word, input int nBits);
        csN = 1'b0;
        #16;
        for (int i = nBits - 1; i >= 0; i--) begin
            si = word[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #8 csN = 1'b1;
        si = ~si;
        #40;
    endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the erase and pause sequencer
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] protectRegion = 5'h00;
    logic [2:0] otpLockBits = 3'h2;
    logic extBusy = 1'b0;
    logic extPausable = 1'b0;
    logic extIsErase = 1'b0;
    logic powerLoss = 1'b0;
    logic sclk, csN, si, writeLatchFlag, opInProgressFlag, pausedFlag, cmdValid, pauseReq, resumeReq;
    logic chipEraseGo, secEraseGo, softReset;
    logic [15:0] statusWord;
    logic [7:0] cmdOp;
    logic [23:0] cmdAddr;
    logic [1:0] secEraseSel;
    logic [31:0] nV = 0, nP = 0, nR = 0, nC = 0, nS = 0, nT = 0, cycles = 0, v;
    int num_errors = 0;
    int checks_done = 0;

    always #2.5 ref_clk = ~ref_clk;

    fesq_spi_host host (.sclk(sclk), .csN(csN), .si(si));

    // latencies long enough that two frames fit inside the pause latency
    fesq_sequencer #(.CHIP_CLEAR_CYC(60), .SMALL_CLEAR_CYC(60), .PROG_PAUSE_CYC(400), .ERASE_PAUSE_CYC(400)) uut (
        .ref_clk(ref_clk), .reset(reset), .sclk(sclk), .csN(csN), .si(si),
        .protectRegion(protectRegion), .otpLockBits(otpLockBits), .extBusy(extBusy),
        .extPausable(extPausable), .extIsErase(extIsErase), .powerLoss(powerLoss),
        .writeLatchFlag(writeLatchFlag), .opInProgressFlag(opInProgressFlag), .pausedFlag(pausedFlag),
        .statusWord(statusWord), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
        .pauseReq(pauseReq), .resumeReq(resumeReq), .chipEraseGo(chipEraseGo),
        .secEraseGo(secEraseGo), .secEraseSel(secEraseSel), .softReset(softReset)
    );

    // ==========================================================
    // pulse counters and hang guard
    always @(posedge ref_clk) begin
        nV <= nV + (cmdValid === 1'b1);
        nP <= nP + (pauseReq === 1'b1);
        nR <= nR + (resumeReq === 1'b1);
        nC <= nC + (chipEraseGo === 1'b1);
        nS <= nS + (secEraseGo === 1'b1);
        nT <= nT + (softReset === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a pulse lands 3..4 edges after chip select rises; 8 edges covers it
    task automatic frame(input logic [31:0] w, input int n);
        host.send(w, n);
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    // looks only after the edge has settled, so a flag set at this edge is not missed
    task automatic wait_paused();
        repeat (1000) if (pausedFlag !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 reset = 1'b0;
        @(posedge ref_clk);
        #1;
        chk({pausedFlag, writeLatchFlag, opInProgressFlag}, 0);
        chk(statusWord, 16'h1000);
        frame(32'h7a, 8); chk(nR, 0);
        frame(32'hc7, 8); chk(nC, 0);
        frame(32'h06, 8);
        protectRegion = 5'h10;
        frame(32'hc7, 8); chk(nC, 0);
        protectRegion = 5'h00;
        frame(32'hc0, 9); chk(nC, 0);
        frame(32'h60, 8); chk(nC, 1);
        chk({opInProgressFlag, statusWord[0]}, 2'b11);
        repeat (80) @(posedge ref_clk);
        chk({opInProgressFlag, writeLatchFlag}, 0);
        frame(32'h06, 8);
        frame(32'h44002000, 32); chk(nS, 0);
        frame(32'h44001200, 32); chk(nS, 0);
        frame(32'h22001000, 31); chk(nS, 0);
        frame(32'h44001000, 32); chk(nS, 1);
        chk({secEraseSel, opInProgressFlag}, 3'b011);
        repeat (80) @(posedge ref_clk);
        chk({opInProgressFlag, writeLatchFlag}, 0);
        extBusy = 1'b1;
        extIsErase = 1'b1;
        frame(32'h75, 8); chk(nP, 0);
        extPausable = 1'b1;
        frame(32'h06, 8);
        frame(32'h75, 8); chk(nP, 1);
        extBusy = 1'b0;
        v = nV;
        frame(32'h03, 8); chk(nV, v);
        frame(32'h05, 8); chk(nV, v + 1);
        wait_paused();
        chk({pausedFlag, writeLatchFlag, statusWord[15]}, 3'b101);
        frame(32'h06, 8); chk(writeLatchFlag, 1);
        v = nV;
        frame(32'h02001000, 32); chk(nV, v + 1);
        chk({cmdOp, cmdAddr}, 32'h02001000);
        frame(32'h6b, 8); chk(nV, v + 1);
        chk(pausedFlag, 1);
        powerLoss = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 powerLoss = 1'b0;
        chk(pausedFlag, 0);
        frame(32'h7a, 8); chk(nR, 0);
        // program pause; no resume has come before it
        extBusy = 1'b1;
        extIsErase = 1'b0;
        frame(32'h75, 8); chk(nP, 2);
        extBusy = 1'b0;
        wait_paused();
        frame(32'h06, 8); chk({pausedFlag, writeLatchFlag}, 2'b10);
        frame(32'h7a, 8); chk(nR, 1);
        chk({pausedFlag, opInProgressFlag}, 2'b01);
        frame(32'h66, 8);
        frame(32'h99, 8); chk(nT, 1);
        chk(opInProgressFlag, 0);
        // no pause follows the last resume: the host gap is longer than this whole run
        close_out();
    end
endmodule
